// ---- rtl/dsps_pkg.sv ----
// How it works
// - each cycle runs offset null, integrate, ramp down, then residue clear unless the skip clear bit is set
// - integration lasts a fixed time, then ramp down follows at once
// - ramp timer starts with ramp down and stops on comparator change
// - comparator high means positive input; sample at integration end as sign
// - comparator delay of about 2 us adds to the measured count
// - comparator level is ignored during offset null
// - residue clearing follows ramp down unless the skip clear control bit is set
// - residue clearing lasts until the comparator returns high
// - integration period is a whole number of mains periods; the default INT_TIME_MS of 33 ms is not
// - ramp down count limit defaults to twice the integration count
// - ramp time runs from phase lines 10 to 11 until comparator falls
// - after residue clearing, drive 01 and hold offset null
// - offset null is the idle state between conversions
package dsps_pkg;
    localparam int CLK_MHZ = 200;
    localparam int INT_TIME_MS = 33;
    localparam int INT_CYCLES = INT_TIME_MS * CLK_MHZ * 1000;
    localparam int NULL_CYCLES = INT_CYCLES;
    localparam int CMP_DELAY_US = 2;
    localparam int CMP_DELAY_CYCLES = CMP_DELAY_US * CLK_MHZ;
    localparam int RAMP_LIMIT_FACTOR = 2;
    localparam int CNT_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_INT_LEN = 8'h0c;
    localparam logic [7:0] ADDR_NULL_LEN = 8'h10;
    localparam logic [7:0] ADDR_RAMP_MAX = 8'h14;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SKIP_CLR_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_OVR_BIT = 2;
    localparam int ST_SIGN_BIT = 3;
    localparam int ST_PHASE_LSB = 4;
    localparam logic [1:0] LINES_NULL = 2'h1;
    localparam logic [1:0] LINES_INT = 2'h2;
    localparam logic [1:0] LINES_RAMP = 2'h3;
    localparam logic [1:0] LINES_CLEAR = 2'h0;

    typedef enum logic [3:0] {
        PH_NULL = 4'h1,
        PH_INT = 4'h2,
        PH_RAMP = 4'h4,
        PH_CLEAR = 4'h8
    } dsps_phase_t;

    typedef struct packed {
        logic sign;
        logic overrange;
        logic [CNT_W-1:0] count;
    } dsps_result_t;
endpackage

// ---- rtl/dsps_timer.sv ----
`timescale 1ns/10ps
module dsps_timer
    import dsps_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic [W-1:0] count,
    output logic atLimit
);
    initial
    begin
        if (W < 2) $error("timer width too small");
    end

    assign atLimit = (count >= limit);

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (run && !atLimit)
            count <= count + W'(1);
    end
endmodule

// ---- rtl/dsps_host.sv ----
`timescale 1ns/10ps
module dsps_host
    import dsps_pkg::*;
#(
    parameter int INT_LEN_DEFAULT = INT_CYCLES,
    parameter int NULL_LEN_DEFAULT = NULL_CYCLES
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic ctlOne,
    output logic ctlTwo,
    input wire logic zeroCrossOut,
    output logic convDone
);
    initial
    begin
        if (INT_LEN_DEFAULT < 1 || NULL_LEN_DEFAULT < 1) $error("phase lengths must be positive");
        if (longint'(INT_LEN_DEFAULT) * RAMP_LIMIT_FACTOR >= 64'h1_0000_0000)
            $error("ramp limit does not fit the counter");
    end

    dsps_phase_t phase_reg;
    dsps_phase_t phase_next;
    logic [CNT_W-1:0] intLen_reg;
    logic [CNT_W-1:0] nullLen_reg;
    logic [CNT_W-1:0] rampMax_reg;
    logic skipClear_reg;
    logic startPend_reg;
    logic busy_reg;
    logic done_reg;
    logic zcPrev_reg;
    logic [1:0] lines_reg;
    dsps_result_t result_reg;
    logic [31:0] rdata_reg;

    logic phaseAtLimit;
    logic [CNT_W-1:0] phaseLimit;
    logic phaseClear;
    logic [CNT_W-1:0] rampCount;
    logic rampAtLimit;
    logic rampClear;
    logic zcFall;
    logic rampEnd;
    logic clearEnd;
    logic nullEnd;
    logic intEnd;
    logic wrCtrl;
    logic wrIntLen;
    logic wrNullLen;
    logic wrRampMax;
    logic rdResult;
    logic startReq;
    logic convFinish;
    logic [31:0] statusWord;
    logic [31:0] ctrlWord;

    assign zcFall = zcPrev_reg && !zeroCrossOut;

    // phase timer serves offset null and integration lengths
    always_comb
    begin
        phaseLimit = nullLen_reg;
        if (phase_reg == PH_INT)
            phaseLimit = intLen_reg - CNT_W'(1);
        else
            phaseLimit = nullLen_reg - CNT_W'(1);
    end

    // offset null must have lasted its minimum and a start be pending
    assign nullEnd = (phase_reg == PH_NULL) && phaseAtLimit && startPend_reg;
    assign intEnd = (phase_reg == PH_INT) && phaseAtLimit;
    // the count limit keeps a stuck comparator from holding ramp down forever
    assign rampEnd = (phase_reg == PH_RAMP) && (zcFall || rampAtLimit);
    // comparator is live here; the line is already high if no overshoot happened
    assign clearEnd = (phase_reg == PH_CLEAR) && zeroCrossOut;

    assign phaseClear = nullEnd || intEnd || rampEnd || clearEnd;
    assign rampClear = intEnd;

    // write address decode kept in one place so every register sees the same strobes
    always_comb
    begin
        wrCtrl = 1'b0;
        wrIntLen = 1'b0;
        wrNullLen = 1'b0;
        wrRampMax = 1'b0;
        if (regWr)
        begin
            if (regAddr == ADDR_CTRL)
                wrCtrl = 1'b1;
            else if (regAddr == ADDR_INT_LEN)
                wrIntLen = 1'b1;
            else if (regAddr == ADDR_NULL_LEN)
                wrNullLen = 1'b1;
            else if (regAddr == ADDR_RAMP_MAX)
                wrRampMax = 1'b1;
        end
    end

    assign rdResult = regRd && (regAddr == ADDR_RESULT);
    assign startReq = wrCtrl && regWdata[CTRL_START_BIT];
    // any return to offset null closes a conversion, with or without residue clearing
    assign convFinish = (phase_next == PH_NULL) && (phase_reg != PH_NULL);

    dsps_timer #(
        .W(CNT_W)
    ) phaseTimer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clear(phaseClear),
        .run(phase_reg == PH_NULL || phase_reg == PH_INT),
        .limit(phaseLimit),
        .count(),
        .atLimit(phaseAtLimit)
    );

    // runs only during ramp down; count starts at the 10 to 11 change
    dsps_timer #(
        .W(CNT_W)
    ) rampTimer (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clear(rampClear),
        .run(phase_reg == PH_RAMP && !zcFall),
        .limit(rampMax_reg),
        .count(rampCount),
        .atLimit(rampAtLimit)
    );

    always_comb
    begin
        phase_next = phase_reg;
        case (phase_reg)
            PH_NULL:
                if (nullEnd)
                    phase_next = PH_INT;
            PH_INT:
                if (intEnd)
                    phase_next = PH_RAMP;
            PH_RAMP:
                if (rampEnd)
                    phase_next = skipClear_reg ? PH_NULL : PH_CLEAR;
            PH_CLEAR:
                if (clearEnd)
                    phase_next = PH_NULL;
            default:
                phase_next = PH_NULL;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            phase_reg <= PH_NULL;
        else
            phase_reg <= phase_next;
    end

    // phase lines come from a flop so the device never sees a glitch between codes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            lines_reg <= LINES_NULL;
        else
        begin
            case (phase_next)
                PH_NULL: lines_reg <= LINES_NULL;
                PH_INT: lines_reg <= LINES_INT;
                PH_RAMP: lines_reg <= LINES_RAMP;
                PH_CLEAR: lines_reg <= LINES_CLEAR;
                default: lines_reg <= LINES_NULL;
            endcase
        end
    end

    assign ctlOne = lines_reg[1];
    assign ctlTwo = lines_reg[0];

    // edge history only meaningful in ramp down; offset null levels never reach it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            zcPrev_reg <= 1'b0;
        else if (phase_reg == PH_RAMP)
            zcPrev_reg <= zeroCrossOut;
        else
            zcPrev_reg <= 1'b1;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            result_reg <= '0;
        else
        begin
            // taken on the last integration cycle, after early chatter at small inputs
            if (intEnd)
                result_reg.sign <= ~zeroCrossOut; // sign set means negative
            if (rampEnd)
            begin
                result_reg.count <= rampCount; // includes comparator delay
                result_reg.overrange <= rampAtLimit && !zcFall;
            end
        end
    end

    // start requests and done flag; a new event beats a software clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startPend_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            if (nullEnd)
                startPend_reg <= 1'b0;
            else if (startReq)
                startPend_reg <= 1'b1;
            if (nullEnd)
                busy_reg <= 1'b1;
            else if (convFinish)
                busy_reg <= 1'b0;
            if (convFinish)
                done_reg <= 1'b1;
            else if (nullEnd || rdResult)
                done_reg <= 1'b0;
        end
    end

    assign convDone = done_reg;

    // field positions come from the package so software and hardware agree
    always_comb
    begin
        statusWord = '0;
        statusWord[ST_BUSY_BIT] = busy_reg;
        statusWord[ST_DONE_BIT] = done_reg;
        statusWord[ST_OVR_BIT] = result_reg.overrange;
        statusWord[ST_SIGN_BIT] = result_reg.sign;
        statusWord[ST_PHASE_LSB +: 4] = phase_reg;
    end

    always_comb
    begin
        ctrlWord = '0;
        ctrlWord[CTRL_START_BIT] = startPend_reg;
        ctrlWord[CTRL_SKIP_CLR_BIT] = skipClear_reg;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            intLen_reg <= CNT_W'(INT_LEN_DEFAULT);
            nullLen_reg <= CNT_W'(NULL_LEN_DEFAULT);
            rampMax_reg <= CNT_W'(INT_LEN_DEFAULT * RAMP_LIMIT_FACTOR);
            skipClear_reg <= 1'b0;
        end
        else
        begin
            // zero lengths would stall the phase timer; they are forced to one
            if (wrIntLen)
                intLen_reg <= (regWdata == '0) ? CNT_W'(1) : regWdata;
            if (wrNullLen)
                nullLen_reg <= (regWdata == '0) ? CNT_W'(1) : regWdata;
            if (wrRampMax)
                rampMax_reg <= regWdata;
            if (wrCtrl)
                skipClear_reg <= regWdata[CTRL_SKIP_CLR_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= '0;
        else if (regRd)
        begin
            if (regAddr == ADDR_CTRL)
                rdata_reg <= ctrlWord;
            else if (regAddr == ADDR_STATUS)
                rdata_reg <= statusWord;
            else if (regAddr == ADDR_RESULT)
                rdata_reg <= result_reg.count;
            else if (regAddr == ADDR_INT_LEN)
                rdata_reg <= intLen_reg;
            else if (regAddr == ADDR_NULL_LEN)
                rdata_reg <= nullLen_reg;
            else if (regAddr == ADDR_RAMP_MAX)
                rdata_reg <= rampMax_reg;
            else
                rdata_reg <= '0;
        end
        else
            rdata_reg <= '0;
    end

    assign regRdata = rdata_reg;
endmodule

// ---- tb/dsps_host_properties.sv ----
`timescale 1ns/10ps
module dsps_host_chk
    import dsps_pkg::*;
#(
    parameter int INT_LEN_DEFAULT = INT_CYCLES,
    parameter int NULL_LEN_DEFAULT = NULL_CYCLES
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic ctlOne,
    input wire logic ctlTwo,
    input wire logic zeroCrossOut,
    input wire logic convDone
);
    logic [1:0] lines;
    int intCnt_reg;
    int nullCnt_reg;
    assign lines = {ctlOne, ctlTwo};
    // run lengths of the current phase, zero outside it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            intCnt_reg <= 0;
            nullCnt_reg <= 0;
        end
        else
        begin
            intCnt_reg <= (lines == LINES_INT) ? intCnt_reg + 1 : 0;
            nullCnt_reg <= (lines == LINES_NULL) ? nullCnt_reg + 1 : 0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    chk_null_then_int: assert property (lines == LINES_NULL ##1 lines != LINES_NULL |-> lines == LINES_INT)
        else $error("null phase left to a wrong phase");
    chk_null_length: assert property (lines == LINES_NULL ##1 lines == LINES_INT |-> nullCnt_reg >= NULL_LEN_DEFAULT)
        else $error("null phase too short");
    chk_int_length: assert property (lines == LINES_INT ##1 lines != LINES_INT |-> intCnt_reg == INT_LEN_DEFAULT)
        else $error("integration length wrong");
    chk_int_then_ramp: assert property (lines == LINES_INT ##1 lines != LINES_INT |-> lines == LINES_RAMP)
        else $error("integration not followed by ramp down");
    chk_ramp_exit: assert property (lines == LINES_RAMP ##1 lines != LINES_RAMP |-> lines inside {LINES_CLEAR, LINES_NULL})
        else $error("ramp down left to a wrong phase");
    chk_ramp_stop: assert property (lines == LINES_RAMP && $past(lines) == LINES_RAMP && $past(zeroCrossOut) && !zeroCrossOut |=> lines != LINES_RAMP)
        else $error("ramp down kept after comparator fell");
    chk_clear_exit: assert property (lines == LINES_CLEAR && zeroCrossOut |=> lines == LINES_NULL)
        else $error("residue clear not ended on comparator high");
    chk_clear_hold: assert property (lines == LINES_CLEAR && !zeroCrossOut |=> lines == LINES_CLEAR)
        else $error("residue clear ended early");
    chk_done_idle: assert property ($rose(convDone) |-> lines == LINES_NULL)
        else $error("done raised outside offset null");
endmodule

bind dsps_host dsps_host_chk #(
    .INT_LEN_DEFAULT(INT_LEN_DEFAULT),
    .NULL_LEN_DEFAULT(NULL_LEN_DEFAULT)
) u_dsps_host_chk (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ctlOne(ctlOne),
    .ctlTwo(ctlTwo),
    .zeroCrossOut(zeroCrossOut),
    .convDone(convDone)
);

// ---- tb/dsps_front_model.sv ----
`timescale 1ns/10ps
module dsps_front_model
(
    input wire logic core_clk,
    input wire logic ctlOne,
    input wire logic ctlTwo,
    input wire logic signed [15:0] vin,
    output logic zeroCrossOut
);
    logic [1:0] lines;
    int acc = 0;
    int clrCnt = 0;
    logic junk = 1'b0;
    // core_clk is only a time base; the phase follows the lines with no latch
    assign lines = {ctlOne, ctlTwo};
    always @(posedge core_clk)
    begin
        junk <= ~junk;
        clrCnt <= (lines == 2'h0) ? clrCnt + 1 : 0;
        case (lines)
            2'h1: acc <= 0;
            2'h2: acc <= acc + vin;
            2'h3: acc <= (acc > 0) ? acc - 1 : (acc < 0) ? acc + 1 : 0;
            default: acc <= 0;
        endcase
    end
    // undefined level in null is shown as a toggling pattern
    assign zeroCrossOut = (lines == 2'h2) ? (vin > 0) :
        (lines == 2'h3) ? (acc != 0) :
        (lines == 2'h0) ? (clrCnt >= 3) : junk;
endmodule

// ---- tb/dsps_host_tb.sv ----
`timescale 1ns/10ps
module dsps_host_tb
    import dsps_pkg::*;
();
    localparam int LEN = 20;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic ctlOne;
    logic ctlTwo;
    logic zeroCrossOut;
    logic convDone;
    logic signed [15:0] vin = 16'sh0001;
    int error_cnt = 0;
    int checked = 0;
    dsps_host #(.INT_LEN_DEFAULT(LEN), .NULL_LEN_DEFAULT(LEN)) u_dsps_host (
        .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ctlOne(ctlOne),
        .ctlTwo(ctlTwo), .zeroCrossOut(zeroCrossOut), .convDone(convDone));
    dsps_front_model u_dsps_front_model (.core_clk(core_clk), .ctlOne(ctlOne),
        .ctlTwo(ctlTwo), .vin(vin), .zeroCrossOut(zeroCrossOut));
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        cmp({30'h0, ctlOne, ctlTwo}, 32'h1);
        rd(ADDR_STATUS, d);
        cmp(d, 32'h10);
        rd(ADDR_INT_LEN, d);
        cmp(d, LEN);
        rd(8'h18, d);
        cmp(d, 32'h0);
        rd(ADDR_NULL_LEN, d);
        cmp(d, 32'(LEN));
        rd(ADDR_RAMP_MAX, d);
        cmp(d, 32'(2 * LEN));
        wr(ADDR_RAMP_MAX, 32'h1e);
        rd(ADDR_RAMP_MAX, d);
        cmp(d, 32'h1e);
    endtask
    // count may carry a few cycles of comparator and sampling delay
    task automatic conv(input logic signed [15:0] v, input logic [31:0] ctrl,
        input logic [31:0] cnt, input logic [3:0] st);
        logic [31:0] d;
        int n;
        logic sawClr;
        vin <= v;
        wr(ADDR_CTRL, ctrl);
        n = 0;
        sawClr = 1'b0;
        while (convDone !== 1'b1 && n < 500)
        begin
            @(posedge core_clk);
            n++;
            if ({ctlOne, ctlTwo} == LINES_CLEAR)
                sawClr = 1'b1;
        end
        cmp({31'h0, convDone}, 32'h1);
        cmp({31'h0, sawClr}, {31'h0, ~ctrl[CTRL_SKIP_CLR_BIT]});
        rd(ADDR_STATUS, d);
        cmp({24'h0, d[7:0]}, {24'h0, 4'h1, st});
        rd(ADDR_RESULT, d);
        cmp(d inside {[cnt - 2 : cnt + 3]} ? cnt : d, cnt);
        cmp({31'h0, convDone}, 32'h0);
    endtask
    task automatic t_pos();
        conv(16'sh0001, 32'h1, 32'h14, 4'h2);
    endtask
    task automatic t_neg();
        conv(-16'sh0001, 32'h1, 32'h14, 4'ha);
    endtask
    task automatic t_ovr();
        conv(16'sh0003, 32'h1, 32'h1e, 4'h6);
    endtask
    task automatic t_skip();
        conv(16'sh0001, 32'h3, 32'h14, 4'h2);
    endtask
    initial
    begin
        #20000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_pos();
        t_neg();
        t_ovr();
        t_skip();
        finish_test();
    end
endmodule
